// ### rtl/push_pull_master.sv
// Single-wire push-pull frame master with an Avalon-MM register slave
`timescale 1ns/1ns
`include "mpush_defs.svh"
module push_pull_master
  import mpush_pkg::*;
#(
  parameter int PULL_BITS = 8,
  parameter int EOF_SLOTS = 4
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             push_out_pin,
  input  wire logic        pull_in_pin
);

  master_s s_ff;
  master_s nxt_s;

  slot_if sif ();

  logic       req;
  logic       accept;
  logic       wr_data;
  logic       frame_go;
  logic       break_go;
  logic [2:0] code;
  logic [7:0] status_byte;
  logic       busy;

  ////////////////////////////////////////////////////////////////////////////
  // Slot timer
  slot_timer u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tp      (sif.timer)
  );

  assign sif.divisor = s_ff.divisor;
  assign sif.restart = s_ff.restart;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle while read data is prepared
  assign req             = avs_read || avs_write;
  assign accept          = req && s_ff.ack;
  assign avs_waitrequest = req && !s_ff.ack;
  assign avs_readdata    = s_ff.rdata;

  assign busy    = (s_ff.state != ST_IDLE);
  assign wr_data = accept && avs_write && (avs_address == `OFS_FRAME_DATA)
                   && avs_byteenable[0];

  // Data write starts a frame only when idle, enabled and clocked
  assign frame_go = wr_data && s_ff.enable && !busy && (s_ff.divisor != 13'h0);
  assign break_go = s_ff.brk && s_ff.enable && !busy && !frame_go
                    && (s_ff.divisor != 13'h0);

  // Pull code taken from the low three bits of the received byte;
  // the upper pull bits reach software untouched
  assign code = s_ff.pull_sr[2:0];

  // Status byte as software sees it; busy is live, not latched
  always_comb
  begin
    status_byte                  = 8'h00;
    status_byte[`ST_RX_FULL_BIT] = s_ff.rx_full;
    status_byte[`ST_NOISE_BIT]   = s_ff.noise;
    status_byte[`ST_VALID_BIT]   = s_ff.valid;
    status_byte[`ST_FAIL_BIT]    = s_ff.fail;
    status_byte[`ST_BUSY_BIT]    = busy;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: registers, frame sequencer and flags
  always_comb
  begin
    nxt_s         = s_ff;
    nxt_s.restart = 1'b0;

    // Ack toggles so each request sees exactly one wait cycle
    // Costs a cycle per access but keeps read data off a combinational path
    nxt_s.ack = req && !s_ff.ack;

    // Read data latched in the wait cycle, stable at the accepting edge
    if (req && !s_ff.ack)
    begin
      case (avs_address)
        `OFS_RATE_DIVISOR: nxt_s.rdata = {19'h0, s_ff.divisor};
        `OFS_LINK_CONTROL: nxt_s.rdata = {30'h0, s_ff.brk, s_ff.enable};
        `OFS_FRAME_DATA:   nxt_s.rdata = {24'h0, s_ff.data_reg};
        `OFS_LINK_STATUS:  nxt_s.rdata = {24'h0, status_byte};
        default:           nxt_s.rdata = 32'h0;
      endcase
    end

    // Register writes; unmapped offsets are ignored
    if (accept && avs_write)
    begin
      case (avs_address)
        `OFS_RATE_DIVISOR:
        begin
          if (avs_byteenable[0])
            nxt_s.divisor[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1])
            nxt_s.divisor[12:8] = avs_writedata[12:8];
        end
        `OFS_LINK_CONTROL:
        begin
          if (avs_byteenable[0])
          begin
            nxt_s.enable = avs_writedata[`CTL_BUS_MODE_BIT];
            nxt_s.brk    = avs_writedata[`CTL_BREAK_BIT];
          end
        end
        default:
        begin
          nxt_s.enable = s_ff.enable;
        end
      endcase
    end

    // Status read snapshots flags; a later data read clears only those.
    // Snapshot comes from the word software actually received, so a flag
    // that rises between the wait cycle and the accept edge is never lost
    if (accept && avs_read && avs_address == `OFS_LINK_STATUS)
      nxt_s.snap = s_ff.rdata[3:0];
    if (accept && avs_read && avs_address == `OFS_FRAME_DATA)
    begin
      nxt_s.rx_full = s_ff.rx_full && !s_ff.snap[0];
      nxt_s.noise   = s_ff.noise && !s_ff.snap[1];
      nxt_s.valid   = s_ff.valid && !s_ff.snap[2];
      nxt_s.fail    = s_ff.fail && !s_ff.snap[3];
      nxt_s.snap    = 4'h0;
    end

    // Frame sequencer; flag sets below follow the clears so a set wins
    case (s_ff.state)
      ST_IDLE:
      begin
        nxt_s.tx_level = 1'b1;
        if (frame_go)
        begin
          nxt_s.state   = ST_START;
          nxt_s.restart = 1'b1;
          nxt_s.cnt     = 5'h0;
          nxt_s.tx_level = 1'b0;
          // Sent LSB first: sync zero, data, address, pull sync one
          nxt_s.tx_word = {1'b1, avs_writedata[7:0], 1'b0};
        end
        else if (break_go)
        begin
          nxt_s.state    = ST_BREAK;
          nxt_s.restart  = 1'b1;
          nxt_s.cnt      = 5'h0;
          nxt_s.tx_level = 1'b0;
        end
      end

      ST_START:
      begin
        if (sif.slot_tick)
        begin
          if (s_ff.cnt == `START_SLOTS - 5'h1)
          begin
            nxt_s.state    = ST_PUSH;
            nxt_s.cnt      = 5'h0;
            nxt_s.half     = 1'b0;
            nxt_s.tx_level = ~s_ff.tx_word[0];
          end
          else
            nxt_s.cnt = s_ff.cnt + 5'h1;
        end
      end

      ST_PUSH:
      begin
        // Line read back mid-slot; receiver shift register untouched here
        if (sif.mid_tick && (pull_in_pin != s_ff.tx_level))
          nxt_s.noise = 1'b1;
        if (sif.slot_tick)
        begin
          if (!s_ff.half)
          begin
            nxt_s.half     = 1'b1;
            nxt_s.tx_level = s_ff.tx_word[0];
          end
          else if (s_ff.cnt == `PUSH_BITS - 5'h1)
          begin
            // Release the wire to recessive so the slave can answer
            nxt_s.state    = ST_PULL;
            nxt_s.cnt      = 5'h0;
            nxt_s.half     = 1'b0;
            nxt_s.tx_level = 1'b1;
          end
          else
          begin
            nxt_s.half     = 1'b0;
            nxt_s.cnt      = s_ff.cnt + 5'h1;
            nxt_s.tx_word  = {1'b0, s_ff.tx_word[9:1]};
            nxt_s.tx_level = ~s_ff.tx_word[1];
          end
        end
      end

      ST_PULL:
      begin
        // NRZ sample mid-slot, LSB first
        if (sif.mid_tick)
          nxt_s.pull_sr = {pull_in_pin, s_ff.pull_sr[7:1]};
        if (sif.slot_tick)
        begin
          if (s_ff.cnt == 5'(PULL_BITS - 1))
          begin
            nxt_s.state    = ST_EOF;
            nxt_s.cnt      = 5'h0;
            nxt_s.eof_ones = 1'b1;
            nxt_s.eof_alt  = 1'b1;
          end
          else
            nxt_s.cnt = s_ff.cnt + 5'h1;
        end
      end

      ST_EOF:
      begin
        // A slot-rate toggle is a square wave at the push bit rate
        if (sif.mid_tick)
        begin
          nxt_s.eof_ones = s_ff.eof_ones && pull_in_pin;
          if (s_ff.cnt != 5'h0)
            nxt_s.eof_alt = s_ff.eof_alt && (pull_in_pin != s_ff.eof_prev);
          nxt_s.eof_prev = pull_in_pin;
        end
        if (sif.slot_tick)
        begin
          if (s_ff.cnt == 5'(EOF_SLOTS - 1))
          begin
            nxt_s.state    = ST_IDLE;
            nxt_s.cnt      = 5'h0;
            nxt_s.data_reg = s_ff.pull_sr;
            nxt_s.rx_full  = 1'b1;
            // Valid and failed exclude each other: only code 111 can fail
            if ((code != `CODE_ALL_ONES) && (code != `CODE_ALL_ZEROS) && s_ff.eof_alt)
              nxt_s.valid = 1'b1;
            if ((code == `CODE_ALL_ONES) && s_ff.eof_ones)
              nxt_s.fail = 1'b1;
          end
          else
            nxt_s.cnt = s_ff.cnt + 5'h1;
        end
      end

      ST_BREAK:
      begin
        // Break ignores the line; nothing is read back while it runs
        if (sif.slot_tick)
        begin
          if (s_ff.cnt == `BREAK_SLOTS - 5'h1)
          begin
            nxt_s.state    = ST_IDLE;
            nxt_s.cnt      = 5'h0;
            nxt_s.brk      = 1'b0;
            nxt_s.tx_level = 1'b1;
          end
          else
            nxt_s.cnt = s_ff.cnt + 5'h1;
        end
      end

      default:
      begin
        nxt_s.state    = ST_IDLE;
        nxt_s.tx_level = 1'b1;
      end
    endcase

    // Leaving bus mode abandons any frame and frees the wire
    if (!nxt_s.enable)
    begin
      nxt_s.state    = ST_IDLE;
      nxt_s.tx_level = 1'b1;
      nxt_s.cnt      = 5'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit pin straight from a flop; tx_level is forced high whenever bus
  // mode is off, so the pin rests recessive with no gate after the flop
  always_comb
  begin
    push_out_pin = s_ff.tx_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_ff          <= '0;
      s_ff.state    <= ST_IDLE;
      s_ff.divisor  <= `DIVISOR_RESET;
      s_ff.tx_level <= 1'b1;
      s_ff.eof_ones <= 1'b1;
      s_ff.eof_alt  <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

endmodule

// ### rtl/mpush_defs.svh
// Offsets, field positions, reset values and counts of the push-pull frame master
`ifndef MPUSH_DEFS_SVH
`define MPUSH_DEFS_SVH

// Register byte offsets
`define OFS_RATE_DIVISOR   4'h0
`define OFS_LINK_CONTROL   4'h4
`define OFS_FRAME_DATA     4'h8
`define OFS_LINK_STATUS    4'hc

// Control field positions
`define CTL_BUS_MODE_BIT   0
`define CTL_BREAK_BIT      1

// Status field positions
`define ST_RX_FULL_BIT     0
`define ST_NOISE_BIT       1
`define ST_VALID_BIT       2
`define ST_FAIL_BIT        3
`define ST_BUSY_BIT        4

// Push data and address layout in the data byte
`define PUSH_DATA_LSB      0
`define PUSH_DATA_W        5
`define PUSH_ADDR_LSB      5
`define PUSH_ADDR_W        3

// Frame timing: rates in Hz, sub-ticks per slot, field lengths in time slots or push bits
`define PUSH_RATE_HZ       20000
`define CLK_HZ             100000000
`define SUB_TICKS          16
`define SUB_MID            4'h7
`define SUB_LAST           4'hf
`define START_SLOTS        5'h03
`define PUSH_BITS          5'h0a
`define BREAK_SLOTS        5'h14
`define EOF_SLOTS          5'h04

// Divisor giving one slot per half push bit; rounds down, so the rate is slightly fast
`define DIVISOR_RESET      13'((`CLK_HZ) / ((`SUB_TICKS) * 2 * (`PUSH_RATE_HZ)))

// Pull code limits
`define CODE_ALL_ONES      3'h7
`define CODE_ALL_ZEROS     3'h0

`endif

// ### rtl/mpush_pkg.sv
// Types shared by the push-pull frame master and its slot timer
package mpush_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_PUSH  = 3'b010,
    ST_PULL  = 3'b011,
    ST_EOF   = 3'b100,
    ST_BREAK = 3'b101
  } frame_state_e;

  typedef struct packed {
    logic [12:0] pre;
    logic [3:0]  sub;
  } timer_s;

  typedef struct packed {
    frame_state_e state;
    logic [12:0]  divisor;
    logic         enable;
    logic         brk;
    logic [9:0]   tx_word;
    logic [7:0]   pull_sr;
    logic [7:0]   data_reg;
    logic [4:0]   cnt;
    logic         half;
    logic         tx_level;
    logic         restart;
    logic         rx_full;
    logic         noise;
    logic         valid;
    logic         fail;
    logic [3:0]   snap;
    logic         ack;
    logic [31:0]  rdata;
    logic         eof_prev;
    logic         eof_ones;
    logic         eof_alt;
  } master_s;

endpackage

// ### rtl/slot_if.sv
// Slot timing signals between the frame engine and its slot timer
`timescale 1ns/1ns
interface slot_if;
  logic [12:0] divisor;
  logic        restart;
  logic        slot_tick;
  logic        mid_tick;

  modport timer (input divisor, input restart, output slot_tick, output mid_tick);
  modport user  (output divisor, output restart, input slot_tick, input mid_tick);
endinterface

// ### rtl/slot_timer.sv
// Rate generator: sixteen sub-ticks per time slot, slot end and mid-slot pulses
`timescale 1ns/1ns
`include "mpush_defs.svh"
module slot_timer
  import mpush_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  slot_if.timer     tp
);

  timer_s t_ff;
  timer_s nxt_t;
  logic   pre_wrap;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler wraps every divisor clocks; zero divisor keeps everything still
  always_comb
  begin
    nxt_t    = t_ff;
    pre_wrap = 1'b0;
    if (tp.restart || tp.divisor == 13'h0)
    begin
      nxt_t.pre = 13'h0;
      nxt_t.sub = 4'h0;
    end
    else if (t_ff.pre + 13'h1 >= tp.divisor)
    begin
      pre_wrap  = 1'b1;
      nxt_t.pre = 13'h0;
      nxt_t.sub = t_ff.sub + 4'h1;
    end
    else
    begin
      nxt_t.pre = t_ff.pre + 13'h1;
    end
  end

  // Slot ends on the sixteenth sub-tick; sampling sits mid-slot, away from edges
  assign tp.slot_tick = pre_wrap && (t_ff.sub == `SUB_LAST);
  assign tp.mid_tick  = pre_wrap && (t_ff.sub == `SUB_MID);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      t_ff <= '0;
    else
      t_ff <= nxt_t;
  end

endmodule

// ### bench/push_pull_master_props.sv
// Concurrent checks on the frame master's bus handshake and wire timing
`timescale 1ns/1ns
module push_pull_master_props #(
  parameter int PULL_BITS = 8,
  parameter int EOF_SLOTS = 4
)
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        push_out_pin,
  input wire logic        pull_in_pin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire req = avs_read | avs_write;
  wire unmapped_rd = avs_read && !(avs_address inside {4'h0, 4'h4, 4'h8, 4'hc});
  ////////////////////////////////////////////////////////////////////////////
  // Handshake steps: one wait cycle, then the accepting cycle
  sequence s_wait;
    req && avs_waitrequest;
  endsequence
  sequence s_take;
    req && !avs_waitrequest;
  endsequence
  chk_one_wait_cycle: assert property ($rose(req) |-> s_wait ##1 s_take)
    else $error("request not accepted after exactly one wait cycle");
  chk_take_after_wait: assert property (s_take |-> $past(req) && $past(avs_waitrequest))
    else $error("request accepted without a wait cycle");
  chk_idle_no_wait: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  chk_unmapped_zero: assert property (s_take and unmapped_rd |-> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  chk_read_data_hold: assert property (!req && !$past(req) |-> $stable(avs_readdata))
    else $error("read data changed between requests");
  ////////////////////////////////////////////////////////////////////////////
  // A slot is at least sixteen clocks; each level on the wire is only checked to last eight
  chk_low_slot_min: assert property ($fell(push_out_pin) |-> !push_out_pin [*8])
    else $error("low level on wire shorter than a slot");
  chk_high_slot_min: assert property ($rose(push_out_pin) |-> push_out_pin [*8])
    else $error("high level on wire shorter than a slot");
  chk_reset_released: assert property ($fell(rst) |-> push_out_pin)
    else $error("wire driven low right after reset");
endmodule
bind push_pull_master push_pull_master_props #(.PULL_BITS(PULL_BITS), .EOF_SLOTS(EOF_SLOTS))
  chk_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .push_out_pin(push_out_pin), .pull_in_pin(pull_in_pin));

// ### bench/wire_slave_model.sv
// Behavioural slave on the single wire: records the push field, answers a pull field
`timescale 1ns/1ns
module wire_slave_model #(
  parameter int SLOT = 16
)
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       line,
  input  wire logic [7:0] reply,
  input  wire logic [1:0] mode,
  output logic            drive,
  output logic [22:0]     seen,
  output logic [2:0]      errs,
  output logic            active
);
  int          cyc;
  int          slot;
  logic        line_q;
  logic [22:0] seen_b;
  assign slot = cyc / SLOT;
  // Level let onto the wire per slot; 1 is released, the pull-up wins
  function automatic logic lvl(input int s);
    if (mode == 2'h2 && s == 3)
      return 1'b0;
    if (s >= 23 && s < 31)
      return reply[s - 23];
    if (s >= 31 && s < 35)
      return (mode == 2'h1) ? 1'b1 : s[0];
    return 1'b1;
  endfunction
  // Frame follower keyed on a fall from idle; slot timing matches divisor 1
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cyc <= 0;
      active <= 1'b0;
      seen <= 23'h0;
      seen_b <= 23'h0;
      drive <= 1'b1;
      line_q <= 1'b1;
    end
    else
    begin
      line_q <= line;
      if (!active)
      begin
        active <= line_q & ~line;
        cyc <= 2;
      end
      else
      begin
        cyc <= cyc + 1;
        if (slot < 23 && cyc % SLOT == SLOT / 2)
          seen[slot] <= line;
        if (slot < 23 && cyc % SLOT == SLOT * 3 / 4)
          seen_b[slot] <= line;
        if (cyc % SLOT == 1)
          drive <= lvl(slot);
        if (slot >= 35)
        begin
          active <= 1'b0;
          drive <= 1'b1;
        end
      end
    end
  end
  // Slave-side errors over the last push field: noise, biphase, field
  always_comb
  begin
    errs = 3'h0;
    errs[0] = |(seen ^ seen_b);
    for (int k = 0; k < 10; k++)
      if (seen[3 + 2 * k] == seen[4 + 2 * k])
        errs[1] = 1'b1;
    errs[2] = (seen[2:0] != 3'h0) || (seen[4:3] != 2'b01) || (seen[22:21] != 2'b10);
  end
endmodule

// ### bench/push_pull_master_tb.sv
// Self-checking bench for the push-pull frame master with a slave on the wire
`timescale 1ns/1ns
`include "mpush_defs.svh"
module push_pull_master_tb;
  import mpush_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        push_out_pin;
  logic        drive;
  logic [22:0] seen;
  logic [2:0]  errs;
  logic        active;
  logic [7:0]  reply = 8'h0;
  logic [1:0]  mode = 2'h0;
  logic [31:0] q;
  int          miscompares = 0;
  int          checks = 0;
  int          seed = 79;
  // Open-drain wire: either party pulls low, the pull-up holds it high
  wire         line = push_out_pin & drive;
  always #5 ref_clk = ~ref_clk;
  push_pull_master #(.PULL_BITS(8), .EOF_SLOTS(4)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .push_out_pin(push_out_pin), .pull_in_pin(line));
  wire_slave_model #(.SLOT(16)) slave_u (.ref_clk(ref_clk), .rst(rst), .line(line),
    .reply(reply), .mode(mode), .drive(drive), .seen(seen), .errs(errs), .active(active));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic bail();
    miscompares++;
    summarize();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  // One transfer; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (n > 20)
        bail();
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic settle();
    int n;
    n = 0;
    while (active !== 1'b0)
    begin
      @(negedge ref_clk);
      n++;
      if (n > 2000)
        bail();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Slot levels of start and push field, LSB first, sync 0 first, pull sync 1 last
  function automatic logic [22:0] push_slots(input logic [7:0] d);
    logic [9:0]  b;
    logic [22:0] s;
    b = {1'b1, d, 1'b0};
    s = 23'h0;
    for (int k = 0; k < 10; k++)
    begin
      s[3 + 2 * k] = ~b[k];
      s[4 + 2 * k] = b[k];
    end
    return s;
  endfunction
  // Status after a frame: fail, valid, noise, full; square wave unless mode 1
  function automatic logic [4:0] exp_status(input logic [7:0] p, input logic [1:0] m);
    logic sq;
    sq = (m != 2'h1);
    return {1'b0, p[2:0] == 3'h7 && !sq, p[2:0] != 3'h7 && p[2:0] != 3'h0 && sq,
      m == 2'h2, 1'b1};
  endfunction
  // Full frame, with a second data write while busy that must be ignored
  task automatic run_frame(input logic [7:0] d, input logic [7:0] p, input logic [1:0] m);
    int n;
    n = 0;
    reply <= p;
    mode <= m;
    bus(1'b1, `OFS_FRAME_DATA, {24'h0, d});
    bus(1'b1, `OFS_FRAME_DATA, {24'h0, ~d});
    do
    begin
      bus(1'b0, `OFS_LINK_STATUS, 32'h0);
      n++;
      if (n > 400)
        bail();
    end while (q[4] !== 1'b0);
    chk(q[4:0], exp_status(p, m));
    if (m != 2'h2)
      chk(seen, push_slots(d));
    chk(errs, (m == 2'h2) ? 3'h6 : 3'h0);
    bus(1'b0, `OFS_FRAME_DATA, 32'h0);
    chk(q, {24'h0, p});
    bus(1'b0, `OFS_LINK_STATUS, 32'h0);
    chk(q[3:0], 4'h0);
    settle();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] d;
    logic [7:0] p;
    logic [1:0] m;
    int         n;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, `OFS_RATE_DIVISOR, 32'h0);
    chk(q, {19'h0, `DIVISOR_RESET});
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    // Disabled, then divisor zero: data writes must not start a frame
    bus(1'b1, `OFS_FRAME_DATA, 32'h5a);
    bus(1'b0, `OFS_LINK_STATUS, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `OFS_RATE_DIVISOR, 32'h0);
    bus(1'b1, `OFS_LINK_CONTROL, 32'h1);
    bus(1'b1, `OFS_FRAME_DATA, 32'h33);
    bus(1'b0, `OFS_LINK_STATUS, 32'h0);
    chk(q[4], 1'b0);
    chk(push_out_pin, 1'b1);
    bus(1'b1, `OFS_RATE_DIVISOR, 32'h1);
    // Random frames with corner codes: failed slave, 000, jam, 111 with wave
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($random(seed));
      p = 8'($random(seed));
      m = (i == 2 || i == 4) ? 2'(i / 2) : 2'h0;
      if (i == 0 || i == 3)
        p[2:0] = 3'h7;
      if (i == 1)
        p[2:0] = 3'h0;
      if (i == 0)
        m = 2'h1;
      run_frame(d, p, m);
    end
    // Clearing the enable mid-frame releases the wire at once
    bus(1'b1, `OFS_FRAME_DATA, 32'h96);
    repeat (12) @(posedge ref_clk);
    bus(1'b1, `OFS_LINK_CONTROL, 32'h0);
    @(negedge ref_clk);
    chk(push_out_pin, 1'b1);
    settle();
    // Break: twenty slots low, then the control bit clears itself
    bus(1'b1, `OFS_LINK_CONTROL, 32'h3);
    n = 0;
    while (push_out_pin !== 1'b0)
    begin
      @(negedge ref_clk);
      n++;
      if (n > 50)
        bail();
    end
    n = 0;
    while (push_out_pin === 1'b0 && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(n >= 320 && n <= 322, 1'b1);
    bus(1'b0, `OFS_LINK_CONTROL, 32'h0);
    chk(q[1:0], 2'b01);
    settle();
    summarize();
  end
endmodule
